// ---- design/chain_regs_pkg.sv ----
// constants, types and operation list for the chain master staging register bank
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package chain_regs_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] reference_code_low_addr = 8'h1f;
    localparam logic [7:0] reference_code_high_addr = 8'h20;
    localparam logic [7:0] upper_limit_code_low_addr = 8'h21;
    localparam logic [7:0] upper_limit_code_high_addr = 8'h22;
    localparam logic [7:0] lower_limit_code_low_addr = 8'h23;
    localparam logic [7:0] lower_limit_code_high_addr = 8'h24;
    localparam logic [7:0] chain_target_or_broadcast_addr = 8'h25;
    localparam logic [7:0] chain_target_register_addr = 8'h26;
    localparam logic [7:0] chain_write_byte_addr = 8'h27;

    // ------------------------------------------------------------------
    // reset values and field masks
    // ------------------------------------------------------------------
    localparam logic [7:0] reg_reset_value = 8'h00;
    localparam logic [7:0] code_high_mask = 8'h0f;
    localparam logic [7:0] target_mask = 8'h3f;
    localparam logic [7:0] register_addr_mask = 8'h0f;
    localparam logic [7:0] write_byte_mask = 8'hff;
    localparam logic [5:0] broadcast_address = 6'h00;

    // chain command codes, bits 3:1 of the command register
    typedef enum logic [2:0] {
        chain_op_reserved0 = 3'h0,
        chain_op_slave_read = 3'h1,
        chain_op_slave_write = 3'h2,
        chain_op_addr_alloc = 3'h3,
        chain_op_bcast_config = 3'h4,
        chain_op_bcast_write = 3'h5,
        chain_op_reserved6 = 3'h6,
        chain_op_reserved7 = 3'h7
    } chain_op_type;

    // broadcast configuration commands
    localparam logic [5:0] bcmd_nop = 6'h00;
    localparam logic [5:0] bcmd_reference_write = 6'h02;
    localparam logic [5:0] bcmd_timer_write = 6'h03;
    localparam logic [5:0] bcmd_lower_write = 6'h03;
    localparam logic [5:0] bcmd_upper_write = 6'h04;

    // host port write/read request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    // request that the bank hands to the link engine
    typedef struct packed {
        logic start;
        chain_op_type op;
        logic [5:0] target;
        logic [3:0] reg_addr;
        logic [7:0] wdata;
        logic bcast_all;
    } chain_req_type;

    // one 12-bit threshold code
    typedef struct packed {
        logic [11:0] code;
    } threshold_type;

endpackage

// ---- design/byte_reg.sv ----
// one masked 8-bit register with a write enable driven by host or chain writes
`timescale 1ns/1ps
module byte_reg
    import chain_regs_pkg::*;
#(
    parameter logic [7:0] mask = 8'hff
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);

    // ------------------------------------------------------------------
    // storage: reserved bits never take a write
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= reg_reset_value;
        end else if (we) begin
            q <= wdata & mask;
        end
    end

endmodule // byte_reg

// ---- design/chain_master_staging_regs.sv ----
// threshold and chain staging register bank on the four-wire host port
`timescale 1ns/1ps
module chain_master_staging_regs
    import chain_regs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire host_req_type host_req,
    output logic [7:0] host_rdata,
    output logic host_hit,
    input wire logic chain_wr,
    input wire logic [7:0] chain_addr,
    input wire logic [7:0] chain_wdata,
    input wire logic master_mode,
    input wire logic chain_start,
    input wire logic [2:0] chain_op,
    output chain_req_type chain_req,
    output threshold_type reference_code,
    output threshold_type upper_limit_code,
    output threshold_type lower_limit_code
);

    localparam int nregs = 9;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic hit_at(input logic [7:0] a, input logic [7:0] o);
        hit_at = (a == o);
    endfunction

    // write enable: a host write to any register drops a chain write in the same cycle
    function automatic logic write_en(
        input logic host_s,
        input logic chain_s,
        input logic host_w,
        input logic chain_w);
        write_en = (host_w & host_s) | (chain_w & chain_s & ~host_w);
    endfunction

    // write data: the host byte when the host writes, else the chain byte
    function automatic logic [7:0] write_src(
        input logic host_s,
        input logic host_w,
        input logic [7:0] host_d,
        input logic [7:0] chain_d);
        write_src = (host_w & host_s) ? host_d : chain_d;
    endfunction

    // field masks per register; reserved bits never store a write
    localparam logic [7:0] reg_masks [nregs] = '{
        8'hff,
        code_high_mask,
        8'hff,
        code_high_mask,
        8'hff,
        code_high_mask,
        target_mask,
        register_addr_mask,
        write_byte_mask
    };

    logic [7:0] regs [nregs];
    logic [nregs-1:0] host_sel;
    logic [nregs-1:0] chain_sel;
    logic [nregs-1:0] we;
    logic [7:0] wsrc [nregs];
    logic any_hit;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------------
    // per-register select and storage: thresholds from either port,
    // staging registers only from the host port
    // ------------------------------------------------------------------

    // ------------------------------------------------------------------
    // reference code, low byte
    // ------------------------------------------------------------------
    assign host_sel[0] = hit_at(host_req.addr, reference_code_low_addr);
    assign chain_sel[0] = hit_at(chain_addr, reference_code_low_addr);
    assign we[0] = write_en(host_sel[0], chain_sel[0], host_req.wr, chain_wr);
    assign wsrc[0] = write_src(host_sel[0], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[0])
    ) u_reference_code_low (
        .clk(clk),
        .nrst(nrst),
        .we(we[0]),
        .wdata(wsrc[0]),
        .q(regs[0])
    );

    // ------------------------------------------------------------------
    // reference code, high byte
    // ------------------------------------------------------------------
    assign host_sel[1] = hit_at(host_req.addr, reference_code_high_addr);
    assign chain_sel[1] = hit_at(chain_addr, reference_code_high_addr);
    assign we[1] = write_en(host_sel[1], chain_sel[1], host_req.wr, chain_wr);
    assign wsrc[1] = write_src(host_sel[1], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[1])
    ) u_reference_code_high (
        .clk(clk),
        .nrst(nrst),
        .we(we[1]),
        .wdata(wsrc[1]),
        .q(regs[1])
    );

    // ------------------------------------------------------------------
    // upper limit code, low byte
    // ------------------------------------------------------------------
    assign host_sel[2] = hit_at(host_req.addr, upper_limit_code_low_addr);
    assign chain_sel[2] = hit_at(chain_addr, upper_limit_code_low_addr);
    assign we[2] = write_en(host_sel[2], chain_sel[2], host_req.wr, chain_wr);
    assign wsrc[2] = write_src(host_sel[2], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[2])
    ) u_upper_limit_code_low (
        .clk(clk),
        .nrst(nrst),
        .we(we[2]),
        .wdata(wsrc[2]),
        .q(regs[2])
    );

    // ------------------------------------------------------------------
    // upper limit code, high byte
    // ------------------------------------------------------------------
    assign host_sel[3] = hit_at(host_req.addr, upper_limit_code_high_addr);
    assign chain_sel[3] = hit_at(chain_addr, upper_limit_code_high_addr);
    assign we[3] = write_en(host_sel[3], chain_sel[3], host_req.wr, chain_wr);
    assign wsrc[3] = write_src(host_sel[3], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[3])
    ) u_upper_limit_code_high (
        .clk(clk),
        .nrst(nrst),
        .we(we[3]),
        .wdata(wsrc[3]),
        .q(regs[3])
    );

    // ------------------------------------------------------------------
    // lower limit code, low byte
    // ------------------------------------------------------------------
    assign host_sel[4] = hit_at(host_req.addr, lower_limit_code_low_addr);
    assign chain_sel[4] = hit_at(chain_addr, lower_limit_code_low_addr);
    assign we[4] = write_en(host_sel[4], chain_sel[4], host_req.wr, chain_wr);
    assign wsrc[4] = write_src(host_sel[4], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[4])
    ) u_lower_limit_code_low (
        .clk(clk),
        .nrst(nrst),
        .we(we[4]),
        .wdata(wsrc[4]),
        .q(regs[4])
    );

    // ------------------------------------------------------------------
    // lower limit code, high byte
    // ------------------------------------------------------------------
    assign host_sel[5] = hit_at(host_req.addr, lower_limit_code_high_addr);
    assign chain_sel[5] = hit_at(chain_addr, lower_limit_code_high_addr);
    assign we[5] = write_en(host_sel[5], chain_sel[5], host_req.wr, chain_wr);
    assign wsrc[5] = write_src(host_sel[5], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[5])
    ) u_lower_limit_code_high (
        .clk(clk),
        .nrst(nrst),
        .we(we[5]),
        .wdata(wsrc[5]),
        .q(regs[5])
    );

    // ------------------------------------------------------------------
    // target device or broadcast command, host port only
    // ------------------------------------------------------------------
    assign host_sel[6] = hit_at(host_req.addr, chain_target_or_broadcast_addr);
    assign chain_sel[6] = 1'b0;
    assign we[6] = write_en(host_sel[6], chain_sel[6], host_req.wr, chain_wr);
    assign wsrc[6] = write_src(host_sel[6], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[6])
    ) u_chain_target_or_broadcast (
        .clk(clk),
        .nrst(nrst),
        .we(we[6]),
        .wdata(wsrc[6]),
        .q(regs[6])
    );

    // ------------------------------------------------------------------
    // target register address, host port only
    // ------------------------------------------------------------------
    assign host_sel[7] = hit_at(host_req.addr, chain_target_register_addr);
    assign chain_sel[7] = 1'b0;
    assign we[7] = write_en(host_sel[7], chain_sel[7], host_req.wr, chain_wr);
    assign wsrc[7] = write_src(host_sel[7], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[7])
    ) u_chain_target_register (
        .clk(clk),
        .nrst(nrst),
        .we(we[7]),
        .wdata(wsrc[7]),
        .q(regs[7])
    );

    // ------------------------------------------------------------------
    // staged write byte, host port only
    // ------------------------------------------------------------------
    assign host_sel[8] = hit_at(host_req.addr, chain_write_byte_addr);
    assign chain_sel[8] = 1'b0;
    assign we[8] = write_en(host_sel[8], chain_sel[8], host_req.wr, chain_wr);
    assign wsrc[8] = write_src(host_sel[8], host_req.wr, host_req.wdata,
        chain_wdata);

    byte_reg #(
        .mask(reg_masks[8])
    ) u_chain_write_byte (
        .clk(clk),
        .nrst(nrst),
        .we(we[8]),
        .wdata(wsrc[8]),
        .q(regs[8])
    );

    // ------------------------------------------------------------------
    // read mux; reserved bits already zero in storage
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        any_hit = 1'b0;
        for (int i = 0; i < nregs; i++) begin
            if (host_sel[i]) begin
                next_rdata = regs[i] & reg_masks[i];
                any_hit = 1'b1;
            end
        end
    end

    assign host_hit = any_hit;

    // registered read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            host_rdata <= reg_reset_value;
        end else if (host_req.rd) begin
            host_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // threshold codes assembled from low and high bytes
    // ------------------------------------------------------------------
    assign reference_code.code = {regs[1][3:0], regs[0]};
    assign upper_limit_code.code = {regs[3][3:0], regs[2]};
    assign lower_limit_code.code = {regs[5][3:0], regs[4]};

    // ------------------------------------------------------------------
    // request to the link engine, valid only in master mode
    // ------------------------------------------------------------------
    logic valid_op;
    assign valid_op = (chain_op != chain_op_reserved0)
                    & (chain_op != chain_op_reserved6)
                    & (chain_op != chain_op_reserved7);

    assign chain_req.start = chain_start & master_mode & valid_op;
    assign chain_req.op = chain_op_type'(chain_op);
    assign chain_req.target = regs[6][5:0];
    assign chain_req.reg_addr = regs[7][3:0];
    assign chain_req.wdata = regs[8];
    assign chain_req.bcast_all = (chain_op == chain_op_bcast_write)
                               & (regs[6][5:0] == broadcast_address);

endmodule // chain_master_staging_regs

// ---- verification/chain_master_staging_regs_asserts.sv ----
// port assertions for the staging register bank
`timescale 1ns/1ps
module chain_master_staging_regs_asserts
    import chain_regs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire host_req_type host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_hit,
    input wire logic chain_wr,
    input wire logic [7:0] chain_addr,
    input wire logic [7:0] chain_wdata,
    input wire logic master_mode,
    input wire logic chain_start,
    input wire logic [2:0] chain_op,
    input wire chain_req_type chain_req,
    input wire threshold_type reference_code,
    input wire threshold_type upper_limit_code,
    input wire threshold_type lower_limit_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // host request fields
    wire logic wr = host_req.wr;
    wire logic [7:0] a = host_req.addr;
    wire logic [7:0] d = host_req.wdata;
    wire logic [3:0] dl = host_req.wdata[3:0];
    a_start_gate: assert property (
        chain_req.start == (chain_start && master_mode &&
        chain_op inside {[3'h1:3'h5]})) else $error("bad start");
    a_bcast_all: assert property (
        chain_req.bcast_all == (chain_op == 3'h5 &&
        chain_req.target == 6'h00)) else $error("bad bcast");
    a_ref_low: assert property (
        wr && a == 8'h1f |=> reference_code.code[7:0] == $past(d))
        else $error("bad ref low");
    a_upper_high: assert property (
        wr && a == 8'h22 |=> upper_limit_code.code[11:8] == $past(dl))
        else $error("bad upper high");
    a_reg_stage: assert property (
        wr && a == 8'h26 |=> chain_req.reg_addr == $past(dl))
        else $error("bad reg addr");
    a_byte_stage: assert property (
        wr && a == 8'h27 |=> chain_req.wdata == $past(d))
        else $error("bad write byte");
    a_chain_ignored: assert property (
        chain_wr && chain_addr > 8'h24 && !wr |=> $stable(chain_req.wdata)
        && $stable(chain_req.target) && $stable(chain_req.reg_addr))
        else $error("chain wrote staging");
    a_hit_decode: assert property (
        host_hit == (a inside {[8'h1f:8'h27]})) else $error("bad hit");
    a_unmapped_zero: assert property (
        host_req.rd && !host_hit |=> host_rdata == 8'h00)
        else $error("unmapped not zero");
    cover property (chain_req.start && chain_req.bcast_all);
    cover property (host_req.rd && !host_hit);
    cover property (chain_wr && chain_addr > 8'h24);
endmodule // chain_master_staging_regs_asserts

// ---- verification/host_model.sv ----
// host controller model on the four-wire port
`timescale 1ns/1ps
module host_model
    import chain_regs_pkg::*;
(
    input wire logic clk,
    output host_req_type host_req
);
    initial host_req = '0;
    // one write or read pulse, released lines show inverted values
    task automatic req(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(negedge clk);
        host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // host_model

// ---- verification/chain_master_staging_regs_tb.sv ----
// self-checking bench for the staging register bank
`timescale 1ns/1ps
module chain_master_staging_regs_tb
    import chain_regs_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic chain_wr = 1'b0;
    logic master_mode = 1'b0;
    logic chain_start = 1'b0;
    logic [7:0] chain_addr = 8'h00;
    logic [7:0] chain_wdata = 8'h00;
    logic [2:0] chain_op = 3'h0;
    logic rd_seen = 1'b0;
    logic [7:0] host_rdata;
    logic host_hit;
    host_req_type host_req;
    chain_req_type chain_req;
    threshold_type ref_code, up_code, low_code;
    logic [7:0] exp_q[$];
    logic [7:0] val[9];
    logic [7:0] mask[9] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h3f,
        8'h0f, 8'hff};
    logic [5:0] bc[4] = '{bcmd_nop, bcmd_reference_write, bcmd_timer_write,
        bcmd_upper_write};
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'h8ab2;
    initial forever #25 clk = ~clk;
    host_model u_host (.clk(clk), .host_req(host_req));
    chain_master_staging_regs u_dut (.clk(clk), .nrst(nrst),
        .host_req(host_req), .host_rdata(host_rdata), .host_hit(host_hit),
        .chain_wr(chain_wr), .chain_addr(chain_addr),
        .chain_wdata(chain_wdata), .master_mode(master_mode),
        .chain_start(chain_start), .chain_op(chain_op), .chain_req(chain_req),
        .reference_code(ref_code), .upper_limit_code(up_code),
        .lower_limit_code(low_code));
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // host read, expectation noted in the queue
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        u_host.req(1'b0, a, 8'h00);
    endtask
    // three-wire write pulse
    task automatic cw(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        chain_wr = 1'b1;
        chain_addr = a;
        chain_wdata = d;
        @(negedge clk);
        chain_wr = 1'b0;
        chain_addr = ~a;
    endtask
    // read monitor and cycle limit
    always @(posedge clk) begin
        rd_seen <= host_req.rd;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    always @(negedge clk) begin
        if (rd_seen) begin
            check(12'(host_rdata), 12'(exp_q.pop_front()));
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        for (int i = 0; i < 9; i++) rd(8'h1f + i[7:0], 8'h00);
        // random values, read back through the reserved masks
        for (int i = 0; i < 9; i++) begin
            val[i] = 8'($random(seed));
            u_host.req(1'b1, 8'h1f + i[7:0], val[i]);
            rd(8'h1f + i[7:0], val[i] & mask[i]);
        end
        check(ref_code, {val[1][3:0], val[0]});
        check(up_code, {val[3][3:0], val[2]});
        check(low_code, {val[5][3:0], val[4]});
        rd(8'h1e, 8'h00);
        rd(8'h28, 8'h00);
        cw(8'h23, 8'h5a);
        rd(8'h23, 8'h5a);
        cw(8'h27, ~val[8]);
        rd(8'h27, val[8]);
        // every command code, both modes, every broadcast command
        for (int i = 0; i < 32; i++) begin
            u_host.req(1'b1, 8'h25, {2'b11, bc[i[4:3]]});
            @(negedge clk);
            master_mode = !i[3];
            chain_op = i[2:0];
            chain_start = 1'b1;
            #1 check(12'(chain_req.target), 12'(bc[i[4:3]]));
            check(12'(chain_req.op), 12'(i[2:0]));
            check(12'(chain_req.start),
                12'(!i[3] && i[2:0] inside {[1:5]}));
            check(12'(chain_req.bcast_all),
                12'(i[2:0] == 5 && i[4:3] == 0));
        end
        chain_start = 1'b0;
        check(12'(chain_req.reg_addr), 12'(val[7] & mask[7]));
        check(12'(chain_req.wdata), 12'(val[8]));
        repeat (2) @(negedge clk);
        end_of_test();
    end
endmodule // chain_master_staging_regs_tb
bind chain_master_staging_regs chain_master_staging_regs_asserts u_chk (
    .clk(clk), .nrst(nrst), .host_req(host_req), .host_rdata(host_rdata),
    .host_hit(host_hit), .chain_wr(chain_wr), .chain_addr(chain_addr),
    .chain_wdata(chain_wdata), .master_mode(master_mode),
    .chain_start(chain_start), .chain_op(chain_op), .chain_req(chain_req),
    .reference_code(reference_code), .upper_limit_code(upper_limit_code),
    .lower_limit_code(lower_limit_code));
